//--- kbh_pkg.sv
// Package: offsets, fields, commands and timing for the keyboard host port
package kbh_pkg;
   // Port addresses
   localparam logic [7:0] DATA_PORT = 8'h60;
   localparam logic [7:0] CMD_PORT = 8'h64;
   // Status bit positions
   localparam int ST_OUT_FULL = 0;
   localparam int ST_IN_FULL = 1;
   localparam int ST_SYS_FLAG = 2;
   localparam int ST_CMD_DATA = 3;
   localparam int ST_NOT_INHIBIT = 4;
   localparam int ST_AUX_FULL = 5;
   localparam int ST_TIMEOUT = 6;
   localparam int ST_PARITY = 7;
   // Config byte bit positions
   localparam int CFG_XLATE = 6;
   localparam int CFG_AUX_DIS = 5;
   localparam int CFG_KBD_DIS = 4;
   localparam int CFG_SYS_FLAG = 2;
   localparam int CFG_AUX_IRQ = 1;
   localparam int CFG_KBD_IRQ = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'h77;
   // Commands
   localparam logic [7:0] C_RD_CFG = 8'h20;
   localparam logic [7:0] C_WR_CFG = 8'h60;
   localparam logic [7:0] C_TEST_PW = 8'hA4;
   localparam logic [7:0] C_LOAD_PW = 8'hA5;
   localparam logic [7:0] C_EN_PW = 8'hA6;
   localparam logic [7:0] C_AUX_DIS = 8'hA7;
   localparam logic [7:0] C_AUX_EN = 8'hA8;
   localparam logic [7:0] C_AUX_TEST = 8'hA9;
   localparam logic [7:0] C_SELF_TEST = 8'hAA;
   localparam logic [7:0] C_KBD_TEST = 8'hAB;
   localparam logic [7:0] C_KBD_DIS = 8'hAD;
   localparam logic [7:0] C_KBD_EN = 8'hAE;
   localparam logic [7:0] C_RD_IN = 8'hC0;
   localparam logic [7:0] C_POLL_LO = 8'hC1;
   localparam logic [7:0] C_POLL_HI = 8'hC2;
   localparam logic [7:0] C_RD_OUT = 8'hD0;
   localparam logic [7:0] C_WR_GATE = 8'hD1;
   localparam logic [7:0] C_ECHO_KBD = 8'hD2;
   localparam logic [7:0] C_ECHO_AUX = 8'hD3;
   localparam logic [7:0] C_TO_AUX = 8'hD4;
   localparam logic [7:0] C_RD_TEST = 8'hE0;
   localparam logic [3:0] C_PULSE_HI = 4'hF;
   // Replies
   localparam logic [7:0] R_PW_YES = 8'hFA;
   localparam logic [7:0] R_PW_NO = 8'hF1;
   localparam logic [7:0] R_SELF_OK = 8'h55;
   localparam logic [7:0] R_OK = 8'h00;
   localparam logic [7:0] R_CLK_LOW = 8'h01;
   localparam logic [7:0] R_CLK_HIGH = 8'h02;
   localparam logic [7:0] R_DAT_LOW = 8'h03;
   localparam logic [7:0] R_DAT_HIGH = 8'h04;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int PULSE_NS = 6000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [10:0] PULSE_CNT = 11'(PULSE_CYC);
   localparam int PW_DEPTH = 8;
   // Byte plus its source marking
   typedef struct packed {
      logic aux;
      logic [7:0] data;
   } kbh_byte_t;
   // Interpreter states
   typedef enum logic [2:0] {
      KBH_IDLE, KBH_ARG_CFG, KBH_ARG_GATE, KBH_ARG_ECHO_K,
      KBH_ARG_ECHO_A, KBH_ARG_AUX, KBH_ARG_PW
   } kbh_state_t;
endpackage

//--- kbh_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module kbh_sync #(
   parameter int W = 1
) (
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // First stage, read only by q

   // Two stages before any logic reads the pins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta <= '0;
         q <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

//--- kbh_reset_pulse.sv
// Timed active-low reset pulse generator
`timescale 1ns/100ps
module kbh_reset_pulse (
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Control
   input wire logic fire,
   output logic reset_out_n
);
   logic [10:0] count; // Remaining low cycles

   // Low for the full count, retrigger ignored while running
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= '0;
         reset_out_n <= 1'b1;
      end else if (ce) begin
         if (fire && count == '0) begin
            count <= kbh_pkg::PULSE_CNT;
            reset_out_n <= 1'b0;
         end else if (count > 11'd1) begin
            count <= count - 11'd1;
         end else begin
            count <= '0;
            reset_out_n <= 1'b1;
         end
      end
   end
endmodule

//--- kbh_host_port.sv
// Host port of the keyboard controller: buffers, status, command decoder
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Read-only output byte at data port
// - Port picks data or command; status bit3
// - Data goes to keyboard unless parameter awaited
// - Status readable anytime without side effects
// - Bit0 output full, bit1 input full
// - Bit2 mirrors system flag, reset zero
// - Bit4 low while keyboard inhibited
// - Bit5 marks auxiliary byte pending
// - Bit6 time-out, bit7 even parity error
// - Config byte fields steer the controller
// - Password test returns FA or F1
// - Load password to zero, compare keystrokes
// - Enable or disable aux and keyboard
// - Interface tests report line stuck codes
// - Self test returns 55
// - Return input, output port, test inputs
// - Poll input nibbles into status top
// - Next data bit1 sets gate only
// - Echo as keyboard/aux, or send aux
// - Even F command pulses reset 6 us
// - Parity checked, interrupt on output load
module kbh_host_port (
   // Clock and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Host I/O bus (same clock domain)
   input wire logic [7:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Received serial bytes from the link
   input wire logic rx_valid,
   input wire logic rx_aux,
   input wire logic [7:0] rx_data,
   input wire logic rx_parity,
   input wire logic rx_timeout,
   // Bytes to send on the link
   output logic tx_kbd_valid,
   output logic tx_aux_valid,
   output logic [7:0] tx_data,
   // Pins (asynchronous)
   input wire logic [7:0] input_port_one,
   input wire logic [1:0] test_in,
   input wire logic kbd_clk_in,
   input wire logic kbd_dat_in,
   input wire logic aux_clk_in,
   input wire logic aux_dat_in,
   input wire logic inhibit_sw_n,
   // Outputs
   output logic [7:0] output_port_two,
   output logic address_line20_gate,
   output logic system_reset_out,
   output logic kbd_irq,
   output logic aux_irq,
   output logic pw_match,
   output logic kbd_disabled,
   output logic aux_disabled
);
   //////////////////////////////////////////////////////////////////////////
   // Synchronised pins
   logic [7:0] p1_s;
   logic [1:0] test_s;
   logic [3:0] lines_s; // kbd clk, kbd dat, aux clk, aux dat
   logic inhibit_n_s;

   kbh_sync #(.W(15)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .d({input_port_one, test_in, kbd_clk_in, kbd_dat_in,
          aux_clk_in, aux_dat_in, inhibit_sw_n}),
      .q({p1_s, test_s, lines_s, inhibit_n_s})
   );

   //////////////////////////////////////////////////////////////////////////
   // State
   kbh_pkg::kbh_byte_t out_buf; // Output register and its source
   logic out_full;
   logic in_full;
   logic in_is_cmd;
   logic [7:0] in_byte;
   logic [7:0] cfg;
   logic parity_err;
   logic timeout_err;
   logic [1:0] poll_mode; // 1: low nibble, 2: high nibble
   logic [3:0] poll_nib;
   kbh_pkg::kbh_state_t state;
   logic [7:0] pw_mem [kbh_pkg::PW_DEPTH];
   logic [2:0] pw_len;
   logic [2:0] pw_idx;
   logic pw_loaded;
   logic pw_active;
   // Pending reply from the interpreter
   logic rep_valid;
   kbh_pkg::kbh_byte_t rep;
   logic pulse_fire;
   logic rst_n_int;

   // Host access decode
   wire rd_data = io_rd && io_addr == kbh_pkg::DATA_PORT;
   wire wr_any = io_wr && (io_addr == kbh_pkg::DATA_PORT ||
                           io_addr == kbh_pkg::CMD_PORT);
   // Interpreter takes the input byte when no reply is stalled
   wire take = in_full && !rep_valid;
   // Link byte accepted into output only when empty and no reply waiting
   wire rx_load = rx_valid && !out_full && !rep_valid && ce &&
                  !(rx_aux ? cfg[kbh_pkg::CFG_AUX_DIS]
                           : cfg[kbh_pkg::CFG_KBD_DIS]);

   // Interface test code from synchronised line levels
   function automatic logic [7:0] line_code(input logic c, input logic d);
      if (!c) line_code = kbh_pkg::R_CLK_LOW;
      else if (!d) line_code = kbh_pkg::R_DAT_LOW;
      else line_code = kbh_pkg::R_OK;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Status register view
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[kbh_pkg::ST_OUT_FULL] = out_full;
      status[kbh_pkg::ST_IN_FULL] = in_full;
      status[kbh_pkg::ST_SYS_FLAG] = cfg[kbh_pkg::CFG_SYS_FLAG];
      status[kbh_pkg::ST_CMD_DATA] = in_is_cmd;
      status[kbh_pkg::ST_NOT_INHIBIT] = inhibit_n_s;
      status[kbh_pkg::ST_AUX_FULL] = out_full && out_buf.aux;
      status[kbh_pkg::ST_TIMEOUT] = timeout_err;
      status[kbh_pkg::ST_PARITY] = parity_err;
      // Polled nibble replaces the top bits while polling is on
      if (poll_mode != 2'd0) begin
         status[7:4] = poll_nib;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data register; status read has no side effects
   always_ff @(posedge clk) begin
      if (!nrst) begin
         io_rdata <= 8'h00;
      end else if (ce && io_rd) begin
         if (io_addr == kbh_pkg::DATA_PORT) begin
            io_rdata <= out_buf.data;
         end else if (io_addr == kbh_pkg::CMD_PORT) begin
            io_rdata <= status;
         end else begin
            io_rdata <= 8'h00;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Input buffer: write latches byte and kind, interpreter consumes it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         in_full <= 1'b0;
         in_is_cmd <= 1'b0;
         in_byte <= 8'h00;
      end else if (ce) begin
         // Writes while full are dropped; host must wait
         if (wr_any && !in_full) begin
            in_full <= 1'b1;
            in_byte <= io_wdata;
            in_is_cmd <= io_addr == kbh_pkg::CMD_PORT;
         end else if (take) begin
            in_full <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Output buffer: replies first, then link bytes; read empties it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_full <= 1'b0;
         out_buf <= '0;
      end else if (ce) begin
         if (!out_full && rep_valid) begin
            out_full <= 1'b1;
            out_buf <= rep;
         end else if (rx_load) begin
            out_full <= 1'b1;
            out_buf <= '{aux: rx_aux, data: rx_data};
         end else if (rd_data && out_full) begin
            out_full <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Link error flags, updated with each byte loaded into the output
   always_ff @(posedge clk) begin
      if (!nrst) begin
         parity_err <= 1'b0;
         timeout_err <= 1'b0;
      end else if (ce) begin
         if (rx_load) begin
            parity_err <= ~rx_parity ^ ^rx_data;
         end
         // Time-out is sticky until the next byte loaded into the output
         if (rx_timeout) begin
            timeout_err <= 1'b1;
         end else if (rx_load) begin
            timeout_err <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupt on each output load, gated by config enables
   always_ff @(posedge clk) begin
      if (!nrst) begin
         kbd_irq <= 1'b0;
         aux_irq <= 1'b0;
      end else if (ce) begin
         kbd_irq <= out_full && !out_buf.aux &&
                    cfg[kbh_pkg::CFG_KBD_IRQ];
         aux_irq <= out_full && out_buf.aux &&
                    cfg[kbh_pkg::CFG_AUX_IRQ];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Polling of input port nibbles into status
   always_ff @(posedge clk) begin
      if (!nrst) begin
         poll_nib <= 4'h0;
      end else if (ce) begin
         poll_nib <= (poll_mode == 2'd2) ? p1_s[7:4] : p1_s[3:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command interpreter
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= kbh_pkg::KBH_IDLE;
         cfg <= kbh_pkg::CFG_RESET;
         rep_valid <= 1'b0;
         rep <= '0;
         tx_kbd_valid <= 1'b0;
         tx_aux_valid <= 1'b0;
         tx_data <= 8'h00;
         address_line20_gate <= 1'b0;
         output_port_two <= 8'h00;
         poll_mode <= 2'd0;
         pulse_fire <= 1'b0;
         pw_len <= 3'd0;
         pw_loaded <= 1'b0;
         pw_active <= 1'b0;
      end else if (ce) begin
         tx_kbd_valid <= 1'b0;
         tx_aux_valid <= 1'b0;
         pulse_fire <= 1'b0;
         if (rep_valid && !out_full) begin
            rep_valid <= 1'b0;
         end
         output_port_two[1] <= address_line20_gate;
         output_port_two[0] <= rst_n_int;
         if (take && in_is_cmd) begin
            // Any new command ends polling and parameter waits
            state <= kbh_pkg::KBH_IDLE;
            poll_mode <= 2'd0;
            unique case (in_byte)
               kbh_pkg::C_RD_CFG: begin
                  rep <= '{aux: 1'b0, data: cfg};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_WR_CFG: state <= kbh_pkg::KBH_ARG_CFG;
               kbh_pkg::C_TEST_PW: begin
                  rep <= '{aux: 1'b0, data: pw_loaded ?
                           kbh_pkg::R_PW_YES : kbh_pkg::R_PW_NO};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_LOAD_PW: begin
                  state <= kbh_pkg::KBH_ARG_PW;
                  pw_len <= 3'd0;
                  pw_loaded <= 1'b0;
               end
               kbh_pkg::C_EN_PW: pw_active <= pw_loaded;
               kbh_pkg::C_AUX_DIS: cfg[kbh_pkg::CFG_AUX_DIS] <= 1'b1;
               kbh_pkg::C_AUX_EN: cfg[kbh_pkg::CFG_AUX_DIS] <= 1'b0;
               kbh_pkg::C_KBD_DIS: cfg[kbh_pkg::CFG_KBD_DIS] <= 1'b1;
               kbh_pkg::C_KBD_EN: cfg[kbh_pkg::CFG_KBD_DIS] <= 1'b0;
               kbh_pkg::C_AUX_TEST: begin
                  rep <= '{aux: 1'b0,
                           data: line_code(lines_s[1], lines_s[0])};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_KBD_TEST: begin
                  rep <= '{aux: 1'b0,
                           data: line_code(lines_s[3], lines_s[2])};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_SELF_TEST: begin
                  rep <= '{aux: 1'b0, data: kbh_pkg::R_SELF_OK};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_RD_IN: begin
                  rep <= '{aux: 1'b0, data: p1_s};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_RD_OUT: begin
                  rep <= '{aux: 1'b0, data: output_port_two};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_RD_TEST: begin
                  rep <= '{aux: 1'b0, data: {6'b000000, test_s}};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::C_POLL_LO: poll_mode <= 2'd1;
               kbh_pkg::C_POLL_HI: poll_mode <= 2'd2;
               kbh_pkg::C_WR_GATE: state <= kbh_pkg::KBH_ARG_GATE;
               kbh_pkg::C_ECHO_KBD: state <= kbh_pkg::KBH_ARG_ECHO_K;
               kbh_pkg::C_ECHO_AUX: state <= kbh_pkg::KBH_ARG_ECHO_A;
               kbh_pkg::C_TO_AUX: state <= kbh_pkg::KBH_ARG_AUX;
               default: begin
                  // Only even codes in the top range pulse reset
                  if (in_byte[7:4] == kbh_pkg::C_PULSE_HI && !in_byte[0]) begin
                     pulse_fire <= 1'b1;
                  end
               end
            endcase
         end else if (take) begin
            // Data byte: parameter if one is awaited, else to keyboard
            state <= kbh_pkg::KBH_IDLE;
            unique case (state)
               kbh_pkg::KBH_IDLE: begin
                  tx_kbd_valid <= 1'b1;
                  tx_data <= in_byte;
               end
               kbh_pkg::KBH_ARG_CFG:
                  cfg <= in_byte & kbh_pkg::CFG_WMASK;
               kbh_pkg::KBH_ARG_GATE: address_line20_gate <= in_byte[1];
               kbh_pkg::KBH_ARG_ECHO_K: begin
                  rep <= '{aux: 1'b0, data: in_byte};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::KBH_ARG_ECHO_A: begin
                  rep <= '{aux: 1'b1, data: in_byte};
                  rep_valid <= 1'b1;
               end
               kbh_pkg::KBH_ARG_AUX: begin
                  tx_aux_valid <= 1'b1;
                  tx_data <= in_byte;
               end
               kbh_pkg::KBH_ARG_PW: begin
                  // Zero ends the load; bytes beyond the seventh dropped
                  if (in_byte == 8'h00) begin
                     pw_loaded <= pw_len != 3'd0;
                  end else begin
                     state <= kbh_pkg::KBH_ARG_PW;
                     if (pw_len != 3'(kbh_pkg::PW_DEPTH - 1)) begin
                        pw_len <= pw_len + 3'd1;
                     end
                  end
               end
            endcase
         end
         if (pw_active && pw_match) begin
            pw_active <= 1'b0;
         end
      end
   end

   // Password storage
   always_ff @(posedge clk) begin
      if (ce && take && !in_is_cmd && state == kbh_pkg::KBH_ARG_PW &&
          in_byte != 8'h00) begin
         pw_mem[pw_len] <= in_byte;
      end
   end

   // Keystroke comparison while password checking is active
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pw_idx <= 3'd0;
         pw_match <= 1'b0;
      end else if (ce) begin
         pw_match <= 1'b0;
         if (!pw_active) begin
            pw_idx <= 3'd0;
         end else if (rx_valid && !rx_aux) begin
            if (rx_data == pw_mem[pw_idx]) begin
               if (pw_idx + 3'd1 == pw_len) begin
                  pw_match <= 1'b1;
                  pw_idx <= 3'd0;
               end else begin
                  pw_idx <= pw_idx + 3'd1;
               end
            end else begin
               pw_idx <= 3'd0;
            end
         end
      end
   end

   // Config-derived enables and the reset pin level as registered outputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         kbd_disabled <= 1'b0;
         aux_disabled <= 1'b0;
         system_reset_out <= 1'b1;
      end else if (ce) begin
         kbd_disabled <= cfg[kbh_pkg::CFG_KBD_DIS];
         aux_disabled <= cfg[kbh_pkg::CFG_AUX_DIS];
         system_reset_out <= rst_n_int;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Reset pulse timer
   kbh_reset_pulse u_pulse (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .fire(pulse_fire),
      .reset_out_n(rst_n_int)
   );
endmodule

//--- kbh_host_port_sva.sv
// Checker for the keyboard host port
`timescale 1ns/100ps
module kbh_host_port_sva (
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   // Host bus
   input wire logic [7:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // Side outputs
   input wire logic tx_kbd_valid,
   input wire logic tx_aux_valid,
   input wire logic system_reset_out,
   input wire logic kbd_irq,
   input wire logic aux_irq,
   input wire logic kbd_disabled,
   input wire logic aux_disabled
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Command byte written at the command port
   sequence s_cmd(logic [7:0] c);
      io_wr && io_addr == kbh_pkg::CMD_PORT && io_wdata == c;
   endsequence
   a_unmapped_zero: assert property (io_rd && io_addr != 8'h60
      && io_addr != 8'h64 |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without a read");
   a_tx_pulse: assert property (tx_kbd_valid |=> !tx_kbd_valid)
      else $error("keyboard send longer than one cycle");
   a_tx_one_dest: assert property (!(tx_kbd_valid && tx_aux_valid))
      else $error("byte sent to both devices");
   a_irq_one_src: assert property (!(kbd_irq && aux_irq))
      else $error("both interrupts for one byte");
   a_kbd_off: assert property (s_cmd(8'hAD) |-> ##[1:6] kbd_disabled)
      else $error("keyboard not disabled");
   a_aux_on: assert property (s_cmd(8'hA8) |-> ##[1:6] !aux_disabled)
      else $error("aux not enabled");
   a_pulse_start: assert property (s_cmd(8'hFE) |-> ##[1:8]
      !system_reset_out) else $error("reset pulse missing");
   a_pulse_min: assert property ($fell(system_reset_out) |=>
      !system_reset_out [*8]) else $error("reset pulse too short");
   a_odd_quiet: assert property (s_cmd(8'hFF) ##0 system_reset_out |=>
      system_reset_out [*8]) else $error("odd command pulsed reset");
endmodule
bind kbh_host_port kbh_host_port_sva i_sva (.clk(clk), .nrst(nrst),
   .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
   .io_rdata(io_rdata), .tx_kbd_valid(tx_kbd_valid),
   .tx_aux_valid(tx_aux_valid), .system_reset_out(system_reset_out),
   .kbd_irq(kbd_irq), .aux_irq(aux_irq), .kbd_disabled(kbd_disabled),
   .aux_disabled(aux_disabled));

//--- kbh_link_model.sv
// Link partner: keyboard or aux device answering each byte it is sent
`timescale 1ns/100ps
module kbh_link_model #(
   parameter int DELAY = 6
) (
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   // From controller
   input wire logic tx_kbd_valid,
   input wire logic tx_aux_valid,
   input wire logic [7:0] tx_data,
   input wire logic bad_par,
   // To controller
   output logic rx_valid,
   output logic rx_aux,
   output logic [7:0] rx_data,
   output logic rx_parity,
   output logic [7:0] last_tx
);
   logic [3:0] wait_cnt; // Reply delay, zero when idle
   // Reply with the inverse byte; data toggles when idle so no stale value
   always_ff @(posedge clk) begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      if (!nrst) begin
         wait_cnt <= 4'h0;
      end else if (tx_kbd_valid || tx_aux_valid) begin
         last_tx <= tx_data;
         rx_aux <= tx_aux_valid;
         wait_cnt <= 4'(DELAY);
      end else if (wait_cnt == 4'h1) begin
         rx_valid <= 1'b1;
         rx_data <= ~last_tx;
         rx_parity <= ~(^last_tx) ^ bad_par; // Odd parity unless told
         wait_cnt <= 4'h0;
      end else if (wait_cnt != 4'h0) begin
         wait_cnt <= wait_cnt - 4'h1;
      end
   end
endmodule

//--- tb_top.sv
// Testbench for the keyboard host port
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0; // 250 MHz
   logic nrst = 1'b0;
   logic io_rd = 1'b0;
   logic io_wr = 1'b0;
   logic [7:0] io_addr = 8'h00;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] p1 = 8'h3C; // Input port pins
   logic [1:0] tin = 2'b10; // Test pins
   logic [4:0] ln = 5'b11011; // Inhibit, aux dat/clk, kbd dat/clk
   logic bad_par = 1'b0; // Link fault: bad parity and time-out
   logic rx_valid, rx_aux, rx_parity, tkv, tav, gate, rst_out, kd, ad;
   logic [7:0] io_rdata, rx_data, tx_data, last_tx, op2, s;
   logic [7:0] cmds [7] = '{8'hAA, 8'hA4, 8'hC0, 8'hE0, 8'hAB, 8'hA9, 8'hD0};
   logic [7:0] exps [7] = '{8'h55, 8'hF1, 8'h3C, 8'h02, 8'h00, 8'h01, 8'h01};
   logic [7:0] tgl [6] = '{8'hAE, 8'hA8, 8'hAD, 8'hA7, 8'hC1, 8'hC2};
   logic [7:0] dis [6] = '{8'h12, 8'h10, 8'h11, 8'h13, 8'hC3, 8'h33};
   logic [7:0] pre [4] = '{8'hD2, 8'hD3, 8'h00, 8'hD4};
   logic [7:0] arg [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h81};
   logic [7:0] got [4] = '{8'h5A, 8'hA5, 8'hC3, 8'h7E};
   logic [7:0] ste [4] = '{8'h00, 8'h20, 8'h00, 8'h20};
   int fail_count = 0;
   int checks = 0, n;
   always #2 clk = ~clk;
   kbh_host_port i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .rx_valid(rx_valid), .rx_aux(rx_aux), .rx_data(rx_data),
      .rx_parity(rx_parity), .rx_timeout(bad_par), .tx_kbd_valid(tkv),
      .tx_aux_valid(tav), .tx_data(tx_data), .input_port_one(p1),
      .test_in(tin), .kbd_clk_in(ln[0]), .kbd_dat_in(ln[1]),
      .aux_clk_in(ln[2]), .aux_dat_in(ln[3]), .inhibit_sw_n(ln[4]),
      .output_port_two(op2), .address_line20_gate(gate),
      .system_reset_out(rst_out), .kbd_irq(), .aux_irq(), .pw_match(),
      .kbd_disabled(kd), .aux_disabled(ad));
   kbh_link_model i_link (.clk(clk), .nrst(nrst), .tx_kbd_valid(tkv),
      .tx_aux_valid(tav), .tx_data(tx_data), .bad_par(bad_par),
      .rx_valid(rx_valid), .rx_aux(rx_aux), .rx_data(rx_data),
      .rx_parity(rx_parity), .last_tx(last_tx));
   ////////////////////////////////////////////////////////////////////////
   // Summary and verdict, the one exit
   task automatic complete_run();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         fail_count++;
      end
   endtask
   // Port read; data stands until the next read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      @(negedge clk);
      d = io_rdata;
   endtask
   // Poll one status bit, bounded
   task automatic wait_st(input int b, input logic v);
      logic [7:0] st;
      int k = 0;
      rd(kbh_pkg::CMD_PORT, st);
      while (st[b] !== v && k < 40) begin
         k++;
         rd(kbh_pkg::CMD_PORT, st);
      end
      if (st[b] !== v) begin
         fail_count++;
         complete_run();
      end
   endtask
   // Write once the input side is empty
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wait_st(kbh_pkg::ST_IN_FULL, 1'b0);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   // Wait for output, check masked status, then the byte
   task automatic fetch(input logic [7:0] x, input logic [7:0] m,
      input logic [7:0] e);
      logic [7:0] d;
      wait_st(kbh_pkg::ST_OUT_FULL, 1'b1);
      rd(kbh_pkg::CMD_PORT, d);
      chk(d & m, e);
      rd(kbh_pkg::DATA_PORT, d);
      chk(d, x);
   endtask
   // Command with one reply byte
   task automatic reply(input logic [7:0] c, input logic [7:0] x);
      wr(kbh_pkg::CMD_PORT, c);
      fetch(x, 8'h0B, 8'h09);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      rd(8'h64, s);
      chk(s, 8'h10);
      rd(8'h70, s);
      chk(s, 8'h00);
      for (int i = 0; i < 7; i++) begin
         reply(cmds[i], exps[i]);
      end
      rd(8'h64, s);
      chk(s & 8'h03, 8'h00);
      wr(8'h64, 8'hA5);
      wr(8'h60, 8'h12);
      wr(8'h60, 8'h00);
      reply(8'hA4, 8'hFA);
      wr(8'h64, 8'h60);
      wr(8'h60, 8'hFF);
      reply(8'h20, 8'h77);
      rd(8'h64, s);
      chk(s & 8'h04, 8'h04);
      for (int i = 0; i < 6; i++) begin
         wr(8'h64, tgl[i]);
         repeat (6) @(negedge clk);
         rd(8'h64, s);
         chk({s[7:4], 2'b00, ad, kd}, dis[i]);
      end
      wr(8'h64, 8'h60);
      wr(8'h60, 8'h00);
      for (int i = 0; i < 4; i++) begin
         if (pre[i] != 8'h00) begin
            wr(8'h64, pre[i]);
         end
         wr(8'h60, arg[i]);
         fetch(got[i], 8'h28, ste[i]);
      end
      chk(last_tx, 8'h81);
      bad_par = 1'b1;
      wr(8'h60, 8'h10);
      fetch(8'hEF, 8'hC0, 8'hC0);
      bad_par = 1'b0;
      wr(8'h64, 8'hD1);
      wr(8'h60, 8'h02);
      repeat (6) @(negedge clk);
      chk({op2, 7'h00, gate}, 16'h0301);
      reply(8'hD0, 8'h03);
      wr(8'h64, 8'hFE);
      n = 0;
      while (rst_out !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (rst_out === 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n), 16'(kbh_pkg::PULSE_CYC));
      wr(8'h64, 8'hFF);
      n = 0;
      repeat (20) begin
         @(negedge clk);
         n += int'(rst_out !== 1'b1);
      end
      chk(16'(n), 16'h0000);
      complete_run();
   end
endmodule
